// ---- hdl/ulc_line.sv ----
/*
 ulc_line: serial line with configurable framing, infrared signalling, loopback routing and
 word byte swapping, reached over an Avalon-MM slave with waitrequest.
 Assumes a 25 MHz ref_clk, synchronous active-high sys_rst and rx_pin synchronous to ref_clk.
*/
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module ulc_line (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rx_pin,
   output logic tx_pad_out,
   output logic tx_pad_oe
);
   // byte-enable merge restricted to implemented bits
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be, input logic [31:0] mask);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r & mask;
   endfunction

   logic [31:0] cfg_q, cfg_d, baud_q, baud_d, rd_q, rd_d;
   logic wait_q, wait_d, pad_q, pad_d, oe_q, oe_d;
   logic ack, rx_pop, stat_rd;
   logic txf_in_valid, txf_in_ready, txf_out_valid, txf_out_ready;
   logic [31:0] txf_in_data, txf_out_data, stat_word;
   logic [3:0] txf_level;
   logic [15:0] div_q, div_d;
   logic tick;
   ulc_pkg::ulc_tx_st_t tx_st_q, tx_st_d;
   ulc_pkg::ulc_rx_st_t rx_st_q, rx_st_d;
   logic [3:0] tx_ph_q, tx_ph_d, rx_ph_q, rx_ph_d;
   logic [2:0] tx_idx_q, tx_idx_d, rx_idx_q, rx_idx_d;
   logic [1:0] tx_left_q, tx_left_d, asm_n_q, asm_n_d;
   logic [31:0] tx_word_q, tx_word_d, asm_q, asm_d, rxw_q, rxw_d;
   logic [7:0] tx_byte_q, tx_byte_d, rx_byte_q, rx_byte_d;
   logic tx_stop2_q, tx_stop2_d, rxv_q, rxv_d, perr_q, perr_d, ferr_q, ferr_d, ovr_q, ovr_d;
   logic tx_bit, tx_bit_end, rx_sample, rx_line, rx_dec, ir_pulse, par_on, tx_par_bit;
   logic [1:0] par_sel;

   wire ir_on = cfg_q[ulc_pkg::B_IR];
   wire remote_on = cfg_q[ulc_pkg::B_REMOTE];
   wire echo_on = cfg_q[ulc_pkg::B_ECHO];
   wire local_on = cfg_q[ulc_pkg::B_LOCAL];
   wire out_inv = cfg_q[ulc_pkg::B_OUT_INV];
   wire in_inv = cfg_q[ulc_pkg::B_IN_INV];
   wire [3:0] samp_pos = cfg_q[ulc_pkg::B_SAMP_LO +: 4];
   wire [3:0] ir_width = baud_q[ulc_pkg::B_IRW_LO +: 4];

   assign avs_readdata = rd_q;
   assign avs_waitrequest = wait_q;
   assign tx_pad_out = pad_q;
   assign tx_pad_oe = oe_q;
   assign par_sel = cfg_q[ulc_pkg::B_PAR_LO +: 2];
   assign par_on = (par_sel == ulc_pkg::PAR_EVEN) || (par_sel == ulc_pkg::PAR_ODD);

   // status word assembly
   always_comb begin
      stat_word = 32'h0;
      stat_word[ulc_pkg::S_LVL_LO +: 4] = txf_level;
      stat_word[ulc_pkg::S_RXV] = rxv_q;
      stat_word[ulc_pkg::S_PERR] = perr_q;
      stat_word[ulc_pkg::S_FERR] = ferr_q;
      stat_word[ulc_pkg::S_OVR] = ovr_q;
   end

   // bus slave: one answer cycle per request; a full transmit FIFO holds waitrequest high
   always_comb begin
      ack = 1'b0;
      rx_pop = 1'b0;
      stat_rd = 1'b0;
      txf_in_valid = 1'b0;
      rd_d = rd_q;
      cfg_d = cfg_q;
      baud_d = baud_q;
      if ((avs_read || avs_write) && wait_q) begin
         if (avs_write && avs_address == ulc_pkg::OFF_TXD) begin
            txf_in_valid = 1'b1;
            ack = txf_in_ready;
         end else begin
            ack = 1'b1;
         end
         if (ack && avs_read) begin
            case (avs_address)
               ulc_pkg::OFF_CFG: rd_d = cfg_q;
               ulc_pkg::OFF_BAUD: rd_d = baud_q;
               ulc_pkg::OFF_RXD: begin
                  rd_d = rxw_q;
                  rx_pop = 1'b1;
               end
               ulc_pkg::OFF_STAT: begin
                  rd_d = stat_word;
                  stat_rd = 1'b1;
               end
               default: rd_d = 32'h0;
            endcase
         end
         if (ack && avs_write) begin
            case (avs_address)
               ulc_pkg::OFF_CFG: cfg_d = be_merge(cfg_q, avs_writedata, avs_byteenable,
                                                  ulc_pkg::CFG_MASK);
               ulc_pkg::OFF_BAUD: baud_d = be_merge(baud_q, avs_writedata, avs_byteenable,
                                                    ulc_pkg::BAUD_MASK);
               default: ;
            endcase
         end
      end
      wait_d = !ack;
   end
   assign txf_in_data = cfg_q[ulc_pkg::B_TX_SWAP] ?
                        ulc_pkg::ulc_swap32(avs_writedata) : avs_writedata;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wait_q <= 1'b1;
         rd_q <= 32'h0;
         cfg_q <= ulc_pkg::CFG_RST;
         baud_q <= ulc_pkg::BAUD_RST;
      end else begin
         wait_q <= wait_d;
         rd_q <= rd_d;
         cfg_q <= cfg_d;
         baud_q <= baud_d;
      end
   end

   ulc_fifo #(.WIDTH(ulc_pkg::WORD_W), .DEPTH(ulc_pkg::FIFO_DEPTH)) u_txf (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .in_valid(txf_in_valid),
      .in_ready(txf_in_ready),
      .in_data(txf_in_data),
      .out_valid(txf_out_valid),
      .out_ready(txf_out_ready),
      .out_data(txf_out_data),
      .level(txf_level)
   );

   // sixteenth-bit tick; a divider of n gives n+1 clocks per tick
   assign tick = (div_q == 16'h0);
   assign div_d = tick ? baud_q[ulc_pkg::B_DIV_LO +: 16] : div_q - 16'h1;

   // transmitter: bytes leave each word low byte first
   assign tx_bit_end = tick && (tx_ph_q == ulc_pkg::PH_LAST);
   assign tx_par_bit = (par_sel == ulc_pkg::PAR_ODD) ? ~^tx_byte_q : ^tx_byte_q;
   always_comb begin
      case (tx_st_q)
         ulc_pkg::TX_START: tx_bit = 1'b0;
         ulc_pkg::TX_DATA: tx_bit = tx_byte_q[tx_idx_q];
         ulc_pkg::TX_PAR: tx_bit = tx_par_bit;
         default: tx_bit = 1'b1;
      endcase
   end

   always_comb begin
      tx_st_d = tx_st_q;
      tx_idx_d = tx_idx_q;
      tx_left_d = tx_left_q;
      tx_word_d = tx_word_q;
      tx_byte_d = tx_byte_q;
      tx_stop2_d = tx_stop2_q;
      tx_ph_d = (tick && tx_st_q != ulc_pkg::TX_IDLE) ? tx_ph_q + 4'h1 : tx_ph_q;
      txf_out_ready = 1'b0;
      case (tx_st_q)
         ulc_pkg::TX_IDLE: begin
            tx_ph_d = 4'h0;
            if (tx_left_q != 2'h0) begin
               tx_byte_d = tx_word_q[15:8];
               tx_word_d = {8'h00, tx_word_q[31:8]};
               tx_left_d = tx_left_q - 2'h1;
               tx_st_d = ulc_pkg::TX_START;
            end else if (txf_out_valid) begin
               txf_out_ready = 1'b1;
               tx_word_d = txf_out_data;
               tx_byte_d = txf_out_data[7:0];
               tx_left_d = ulc_pkg::BYTE_LAST;
               tx_st_d = ulc_pkg::TX_START;
            end
         end
         ulc_pkg::TX_START: if (tx_bit_end) begin
            tx_idx_d = 3'h0;
            tx_st_d = ulc_pkg::TX_DATA;
         end
         ulc_pkg::TX_DATA: if (tx_bit_end) begin
            tx_idx_d = tx_idx_q + 3'h1;
            tx_stop2_d = 1'b0;
            if (tx_idx_q == ulc_pkg::BIT_LAST) begin
               tx_st_d = par_on ? ulc_pkg::TX_PAR : ulc_pkg::TX_STOP;
            end
         end
         ulc_pkg::TX_PAR: if (tx_bit_end) begin
            tx_st_d = ulc_pkg::TX_STOP;
         end
         ulc_pkg::TX_STOP: if (tx_bit_end) begin
            // second stop bit only when requested
            if (cfg_q[ulc_pkg::B_STOP] && !tx_stop2_q) begin
               tx_stop2_d = 1'b1;
            end else begin
               tx_st_d = ulc_pkg::TX_IDLE;
            end
         end
         default: tx_st_d = ulc_pkg::TX_IDLE;
      endcase
   end

   // pad drive: remote wins over echo, echo over local; pad enable gates the driver
   assign ir_pulse = !tx_bit && (tx_ph_q < ir_width);
   always_comb begin
      if (remote_on || echo_on) begin
         pad_d = rx_pin;
      end else if (ir_on) begin
         pad_d = ir_pulse ^ out_inv;
      end else begin
         pad_d = tx_bit;
      end
      oe_d = cfg_q[ulc_pkg::B_PAD];
   end

   // receive line selection; remote loopback parks the receiver at idle
   assign rx_dec = ir_on ? ~(rx_pin ^ in_inv) : rx_pin;
   always_comb begin
      if (remote_on) begin
         rx_line = 1'b1;
      end else if (echo_on || !local_on) begin
         rx_line = rx_dec;
      end else begin
         rx_line = tx_bit;
      end
   end

   // receiver; it checks only the first stop bit, so two-stop frames also resync there
   assign rx_sample = tick && (rx_st_q != ulc_pkg::RX_IDLE) && (rx_ph_q == samp_pos);
   always_comb begin
      rx_st_d = rx_st_q;
      rx_idx_d = rx_idx_q;
      rx_byte_d = rx_byte_q;
      asm_d = asm_q;
      asm_n_d = asm_n_q;
      rxw_d = rxw_q;
      rxv_d = rx_pop ? 1'b0 : rxv_q;
      perr_d = stat_rd ? 1'b0 : perr_q;
      ferr_d = stat_rd ? 1'b0 : ferr_q;
      ovr_d = stat_rd ? 1'b0 : ovr_q;
      rx_ph_d = tick ? rx_ph_q + 4'h1 : rx_ph_q;
      case (rx_st_q)
         ulc_pkg::RX_IDLE: begin
            rx_ph_d = 4'h0;
            if (tick && !rx_line) begin
               rx_st_d = ulc_pkg::RX_START;
            end
         end
         ulc_pkg::RX_START: if (rx_sample) begin
            rx_idx_d = 3'h0;
            rx_st_d = rx_line ? ulc_pkg::RX_IDLE : ulc_pkg::RX_DATA;
         end
         ulc_pkg::RX_DATA: if (rx_sample) begin
            rx_byte_d[rx_idx_q] = rx_line;
            rx_idx_d = rx_idx_q + 3'h1;
            if (rx_idx_q == ulc_pkg::BIT_LAST) begin
               rx_st_d = par_on ? ulc_pkg::RX_PAR : ulc_pkg::RX_STOP;
            end
         end
         ulc_pkg::RX_PAR: if (rx_sample) begin
            if (rx_line != ((par_sel == ulc_pkg::PAR_ODD) ? ~^rx_byte_q : ^rx_byte_q)) begin
               perr_d = 1'b1; // set wins over a status read
            end
            rx_st_d = ulc_pkg::RX_STOP;
         end
         ulc_pkg::RX_STOP: if (rx_sample) begin
            if (!rx_line) begin
               ferr_d = 1'b1;
            end
            asm_d[8*asm_n_q +: 8] = rx_byte_q;
            asm_n_d = asm_n_q + 2'h1;
            if (asm_n_q == ulc_pkg::BYTE_LAST) begin
               rxw_d = cfg_q[ulc_pkg::B_RX_SWAP] ? ulc_pkg::ulc_swap32(asm_d) : asm_d;
               ovr_d = ovr_d || (rxv_q && !rx_pop); // a new overrun beats a status read in the same cycle
               rxv_d = 1'b1; // a new word beats a read in the same cycle
            end
            rx_st_d = ulc_pkg::RX_IDLE;
         end
         default: rx_st_d = ulc_pkg::RX_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         div_q <= 16'h0;
         tx_st_q <= ulc_pkg::TX_IDLE;
         tx_ph_q <= 4'h0;
         tx_idx_q <= 3'h0;
         tx_left_q <= 2'h0;
         tx_word_q <= 32'h0;
         tx_byte_q <= 8'h00;
         tx_stop2_q <= 1'b0;
         pad_q <= 1'b1;
         oe_q <= 1'b0;
         rx_st_q <= ulc_pkg::RX_IDLE;
         rx_ph_q <= 4'h0;
         rx_idx_q <= 3'h0;
         rx_byte_q <= 8'h00;
         asm_q <= 32'h0;
         asm_n_q <= 2'h0;
         rxw_q <= 32'h0;
         rxv_q <= 1'b0;
         perr_q <= 1'b0;
         ferr_q <= 1'b0;
         ovr_q <= 1'b0;
      end else begin
         div_q <= div_d;
         tx_st_q <= tx_st_d;
         tx_ph_q <= tx_ph_d;
         tx_idx_q <= tx_idx_d;
         tx_left_q <= tx_left_d;
         tx_word_q <= tx_word_d;
         tx_byte_q <= tx_byte_d;
         tx_stop2_q <= tx_stop2_d;
         pad_q <= pad_d;
         oe_q <= oe_d;
         rx_st_q <= rx_st_d;
         rx_ph_q <= rx_ph_d;
         rx_idx_q <= rx_idx_d;
         rx_byte_q <= rx_byte_d;
         asm_q <= asm_d;
         asm_n_q <= asm_n_d;
         rxw_q <= rxw_d;
         rxv_q <= rxv_d;
         perr_q <= perr_d;
         ferr_q <= ferr_d;
         ovr_q <= ovr_d;
      end
   end

   // checks on the routing, framing and bus answer
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence answer_s;
      !avs_waitrequest;
   endsequence
   sequence stop_end_s;
      tx_st_q == ulc_pkg::TX_STOP && tx_bit_end;
   endsequence

   bus_answer_once_a: assert property (answer_s |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   pad_enable_a: assert property (1'b1 |=> tx_pad_oe == $past(cfg_q[ulc_pkg::B_PAD]))
      else $error("pad enable does not follow configuration");
   sample_point_a: assert property (rx_sample |-> rx_ph_q == samp_pos)
      else $error("receive sample away from selected tick");
   ir_idle_level_a: assert property ((ir_on && !remote_on && !echo_on &&
      tx_st_q == ulc_pkg::TX_IDLE) |=> tx_pad_out == $past(out_inv))
      else $error("infrared idle level wrong for polarity");
   ir_rx_decode_a: assert property ((ir_on && !remote_on && !echo_on && !local_on)
      |-> rx_line == ~(rx_pin ^ in_inv))
      else $error("infrared receive decode wrong");
   echo_route_a: assert property ((echo_on && !remote_on)
      |=> tx_pad_out == $past(rx_pin))
      else $error("echo does not forward receive line");
   remote_route_a: assert property (remote_on
      |-> rx_line ##1 tx_pad_out == $past(rx_pin))
      else $error("remote loopback routing wrong");
   local_route_a: assert property ((local_on && !echo_on && !remote_on)
      |-> rx_line == tx_bit)
      else $error("local loopback does not feed receiver");
   no_parity_a: assert property (tx_st_q == ulc_pkg::TX_PAR |-> par_on)
      else $error("parity bit sent with parity off");
   two_stop_a: assert property ((cfg_q[ulc_pkg::B_STOP] && !tx_stop2_q)
      ##0 stop_end_s |=> tx_st_q == ulc_pkg::TX_STOP)
      else $error("second stop bit missing");
   ir_pulse_end_a: assert property ((ir_on && !remote_on && !echo_on && !tx_bit &&
      tx_ph_q >= ir_width) |=> tx_pad_out == $past(out_inv))
      else $error("infrared pulse too long");
endmodule
`default_nettype wire

// ---- hdl/ulc_pkg.sv ----
/*
 ulc_pkg: constants, register map, field positions, reset values, state codes and the byte
 swap helper for the serial line configuration block.
 Assumes a 32-bit Avalon-MM register bus with byte addresses and a 25 MHz system clock.
*/
package ulc_pkg;
   // register byte offsets
   localparam logic [4:0] OFF_CFG = 5'h00;
   localparam logic [4:0] OFF_BAUD = 5'h04;
   localparam logic [4:0] OFF_TXD = 5'h08;
   localparam logic [4:0] OFF_RXD = 5'h0c;
   localparam logic [4:0] OFF_STAT = 5'h10;
   // line configuration field positions
   localparam int unsigned B_STOP = 0;
   localparam int unsigned B_PAR_LO = 1;
   localparam int unsigned B_TX_SWAP = 3;
   localparam int unsigned B_RX_SWAP = 4;
   localparam int unsigned B_LOCAL = 5;
   localparam int unsigned B_REMOTE = 6;
   localparam int unsigned B_ECHO = 7;
   localparam int unsigned B_IR = 8;
   localparam int unsigned B_IN_INV = 9;
   localparam int unsigned B_OUT_INV = 10;
   localparam int unsigned B_SAMP_LO = 12;
   localparam int unsigned B_PAD = 16;
   localparam logic [31:0] CFG_MASK = 32'h0001_f7ff;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   // baud register: divider low half, infrared pulse width in sixteenths above it
   localparam int unsigned B_DIV_LO = 0;
   localparam int unsigned B_IRW_LO = 16;
   localparam logic [31:0] BAUD_MASK = 32'h000f_ffff;
   localparam logic [31:0] BAUD_RST = 32'h0003_000d;
   // status bit positions
   localparam int unsigned S_LVL_LO = 0;
   localparam int unsigned S_RXV = 8;
   localparam int unsigned S_PERR = 9;
   localparam int unsigned S_FERR = 10;
   localparam int unsigned S_OVR = 11;
   // parity codes
   localparam logic [1:0] PAR_EVEN = 2'h0;
   localparam logic [1:0] PAR_ODD = 2'h1;
   localparam logic [1:0] PAR_NONE = 2'h2;
   // sixteen ticks per bit, eight data bits, four bytes per word
   localparam logic [3:0] PH_LAST = 4'hf;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] BYTE_LAST = 2'h3;
   localparam int unsigned WORD_W = 32;
   localparam int unsigned FIFO_DEPTH = 8;

   typedef enum logic [4:0] {
      TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
   } ulc_tx_st_t;

   typedef enum logic [4:0] {
      RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
   } ulc_rx_st_t;

   // reverse the four bytes of a word
   function automatic logic [31:0] ulc_swap32(input logic [31:0] w);
      logic [31:0] r;
      r = 32'h0;
      for (int i = 0; i < 4; i++) begin
         r[8*i +: 8] = w[8*(3-i) +: 8];
      end
      return r;
   endfunction
endpackage

// ---- hdl/ulc_fifo.sv ----
/*
 ulc_fifo: word FIFO with valid/ready on both sides, width and depth as parameters.
 Assumes one clock, synchronous active-high reset and a power-of-two depth.
*/
`timescale 1ns/1ps
`default_nettype none
module ulc_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 8
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int unsigned PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL = DEPTH[PW:0];

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [PW:0] cnt_q, cnt_d;
   logic push, pop;

   // flags come from the count register, so full and empty are exact
   assign in_ready = (cnt_q != FULL);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign level = cnt_q;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointer and count update
   always_comb begin
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // storage needs no reset; only written words are ever read
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/ulc_remote.sv ----
/*
 ulc_remote: far-side serial transmitter driving the block's receive line.
 Assumes ref_clk as bit timing base and even parity with one stop bit on the block.
*/
`timescale 1ns/1ps
`default_nettype none
module ulc_remote #(
   parameter int BIT_CLKS = 32
) (
   input wire logic ref_clk,
   output logic line_out
);
   // line rests high between frames
   initial line_out = 1'b1;
   // start, eight data lsb first, even parity, one stop
   task automatic send(input logic [7:0] b);
      logic [10:0] f;
      f = {1'b1, ^b, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         line_out <= f[i];
         repeat (BIT_CLKS) @(posedge ref_clk);
      end
   endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
/*
 testbench: register, framing, loopback, swap, fifo and infrared scenarios for ulc_line.
 Assumes the remote model on rx_pin and a 32-clock bit period set through the baud register.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest, rx_pin, tx_pad_out, tx_pad_oe;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   int error_cnt = 0;
   int n_compared = 0;
   ulc_line uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin), .tx_pad_out(tx_pad_out),
      .tx_pad_oe(tx_pad_oe));
   ulc_remote #(.BIT_CLKS(32)) peer (.ref_clk(ref_clk), .line_out(rx_pin));
   // clock at 25 MHz
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one transfer held until waitrequest is seen low; long bound covers a full fifo
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 4000);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // one idle edge so a following call never reassigns a strobe in this time step
      @(posedge ref_clk);
      if (n >= 4000) begin
         chk(0, 1);
         summarize();
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask
   // first byte of a swapped word, sampled mid-bit on the pad
   task automatic t_tx(input logic [1:0] par, input logic st);
      logic [11:0] exp, got;
      int n;
      wr(ulc_pkg::OFF_CFG, 32'h0001_0008 | {par, st});
      wr(ulc_pkg::OFF_TXD, 32'h0403_0201);
      exp = {3'h7, 8'h04, 1'b0};
      if (par != ulc_pkg::PAR_NONE) exp[9] = 1'b1 ^ par[0];
      got = 12'hfff;
      n = 0;
      while (tx_pad_out !== 1'b0 && n < 2000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 2000) begin
         chk(0, 1);
         summarize();
      end
      repeat (14) @(posedge ref_clk);
      for (int i = 0; i < 10 + st + (par != ulc_pkg::PAR_NONE); i++) begin
         got[i] = tx_pad_out;
         repeat (32) @(posedge ref_clk);
      end
      chk(got, exp);
      repeat (1600) @(posedge ref_clk);
   endtask
   // pad must copy the receive line one cycle later
   task automatic t_route(input logic [31:0] cfg);
      logic prev;
      wr(ulc_pkg::OFF_CFG, cfg);
      prev = rx_pin;
      fork
         peer.send(8'h5a);
         for (int i = 0; i < 350; i++) begin
            @(posedge ref_clk);
            chk(tx_pad_out, prev);
            prev = rx_pin;
         end
      join
   endtask
   initial begin
      logic [31:0] q;
      int n;
      int edges, run, max_run;
      logic prev;
      sys_rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      chk(tx_pad_oe, 1'b0);
      rd(ulc_pkg::OFF_CFG, ulc_pkg::CFG_RST);
      rd(ulc_pkg::OFF_BAUD, ulc_pkg::BAUD_RST);
      // parity code 11 is reserved, so all other implemented bits are set
      wr(ulc_pkg::OFF_CFG, 32'hffff_fffb);
      rd(ulc_pkg::OFF_CFG, ulc_pkg::CFG_MASK & 32'hffff_fffb);
      // byte lane 1 alone clears bits 15:8 and leaves the rest
      avs_byteenable <= 4'h2;
      wr(ulc_pkg::OFF_CFG, 32'h0);
      avs_byteenable <= 4'hf;
      rd(ulc_pkg::OFF_CFG, ulc_pkg::CFG_MASK & 32'hffff_00fb);
      rd(5'h14, 32'h0);
      chk(tx_pad_oe, 1'b1);
      wr(ulc_pkg::OFF_BAUD, 32'h0003_0001);
      t_tx(ulc_pkg::PAR_EVEN, 1'b0);
      t_tx(ulc_pkg::PAR_ODD, 1'b1);
      t_tx(ulc_pkg::PAR_NONE, 1'b0);
      // four bytes from the far side, swapped on read
      wr(ulc_pkg::OFF_CFG, 32'h0001_7010);
      peer.send(8'h11);
      peer.send(8'h22);
      peer.send(8'h33);
      peer.send(8'h44);
      repeat (40) @(posedge ref_clk);
      rd(ulc_pkg::OFF_STAT, 32'h0000_0100);
      rd(ulc_pkg::OFF_RXD, 32'h1122_3344);
      // local loop returns the sent word unchanged
      wr(ulc_pkg::OFF_CFG, 32'h0001_7020);
      wr(ulc_pkg::OFF_TXD, 32'ha5c3_0f96);
      repeat (1600) @(posedge ref_clk);
      rd(ulc_pkg::OFF_RXD, 32'ha5c3_0f96);
      t_route(32'h0001_00e0);
      // echo in infrared with the in-invert bit: plain frames still decode
      t_route(32'h0001_7380);
      // receiver kept running under echo, parked under remote: three bytes finish the word
      peer.send(8'h01);
      peer.send(8'h02);
      peer.send(8'h03);
      repeat (40) @(posedge ref_clk);
      rd(ulc_pkg::OFF_RXD, 32'h0302_015a);
      // ten words: the last stalls until the fifo frees a slot
      wr(ulc_pkg::OFF_CFG, 32'h0001_0000);
      for (int i = 0; i < 10; i++) wr(ulc_pkg::OFF_TXD, 32'h0);
      rd(ulc_pkg::OFF_STAT, 32'h0000_0008);
      n = 0;
      q = 32'h1;
      while (q[3:0] !== 4'h0 && n < 400) begin
         bus(1'b0, ulc_pkg::OFF_STAT, 32'h0, q);
         repeat (50) @(posedge ref_clk);
         n++;
      end
      chk(q[3:0], 4'h0);
      if (q[3:0] !== 4'h0) summarize();
      // the last word still leaves the transmitter after the fifo drains
      repeat (1600) @(posedge ref_clk);
      // infrared idle level follows the out-invert bit
      wr(ulc_pkg::OFF_CFG, 32'h0001_0100);
      repeat (2) @(posedge ref_clk);
      chk(tx_pad_out, 1'b0);
      wr(ulc_pkg::OFF_CFG, 32'h0001_0500);
      repeat (2) @(posedge ref_clk);
      chk(tx_pad_out, 1'b1);
      // infrared pulses, no parity: four start bits and four zero data bits in the word, one pulse each
      wr(ulc_pkg::OFF_CFG, 32'h0001_0104);
      wr(ulc_pkg::OFF_TXD, 32'hffff_fff0);
      edges = 0;
      run = 0;
      max_run = 0;
      prev = tx_pad_out;
      for (int i = 0; i < 1400; i++) begin
         @(posedge ref_clk);
         if (tx_pad_out === 1'b1 && prev !== 1'b1) edges++;
         run = (tx_pad_out === 1'b1) ? run + 1 : 0;
         if (run > max_run) max_run = run;
         prev = tx_pad_out;
      end
      chk(edges, 8);
      // width three ticks at divider one, so two clocks a tick
      chk(max_run, 6);
      summarize();
   end
endmodule
`default_nettype wire
